// [fbl_pkg.sv]
package fbl_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] WRITE_ENABLE_CMD          = 8'h06;
  localparam logic [7:0] SINGLE_REGION_LOCK_CMD    = 8'h36;
  localparam logic [7:0] SINGLE_REGION_UNLOCK_CMD  = 8'h39;
  localparam logic [7:0] READ_REGION_LOCK_CMD      = 8'h3d;
  localparam logic [7:0] ALL_REGIONS_LOCK_CMD      = 8'h7e;
  localparam logic [7:0] ALL_REGIONS_UNLOCK_CMD    = 8'h98;
  localparam logic [7:0] RESET_ARM_CMD             = 8'h66;
  localparam logic [7:0] RESET_GO_CMD              = 8'h99;
  localparam logic [7:0] READ_SERIAL_IDENTIFIER_CMD = 8'h4b;
  localparam logic [7:0] READ_PARAMETER_TABLE_CMD  = 8'h5a;

  // ----------------------------------------------------------------
  // Lock map: 128 blocks, bottom and top block also split in sectors
  // ----------------------------------------------------------------
  localparam int          NUM_REGIONS   = 160;
  localparam logic [6:0]  BOTTOM_BLOCK  = 7'h00;
  localparam logic [6:0]  TOP_BLOCK     = 7'h7f;
  localparam logic [7:0]  SECT_BASE_LO  = 8'h80;
  localparam logic [7:0]  SECT_BASE_HI  = 8'h90;
  localparam logic [7:0]  NUM_BLOCKS    = 8'h80;
  localparam logic [3:0]  PROT_ALL      = 4'h8;
  localparam int          BLK_MSB       = 22;
  localparam int          BLK_LSB       = 16;
  localparam int          SECT_MSB      = 15;
  localparam int          SECT_LSB      = 12;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [1:0]  ADDR_LAST     = 2'h2;
  localparam logic [2:0]  STEP_SINGLE   = 3'h1;
  localparam logic [2:0]  STEP_QUAD     = 3'h4;
  localparam logic [7:0]  BLANK_BYTE    = 8'hff;
  localparam int          UID_BYTES     = 16;

  // Parameter table contents
  localparam logic [7:0]  PTAB_LEN      = 8'h08;
  localparam logic [7:0]  PTAB [0:7]    = '{8'h53, 8'h46, 8'h44, 8'h50,
                                            8'h06, 8'h01, 8'h00, 8'hff};

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 10;
  localparam int RESET_PULSE_MIN_NS  = 1000;
  localparam int RESET_PULSE_CYC     =
    (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic       rst_n;
    logic [3:0] lines;
  } fbl_pins_t;

  typedef struct packed {
    logic       protect_select_bit;
    logic       protect_complement_bit;
    logic [4:0] block_protect_field;
  } fbl_prot_cfg_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_OPC   = 6'b000010,
    ST_ADDR  = 6'b000100,
    ST_DUMMY = 6'b001000,
    ST_OUT   = 6'b010000,
    ST_DONE  = 6'b100000
  } fbl_state_t;

endpackage

// [fbl_pin_sync.sv]
`timescale 1ns/1ps
module fbl_pin_sync
  import fbl_pkg::*;
(
  // Clock and reset
  input  wire logic      core_clk,
  input  wire logic      resetn,
  input  wire logic      clk_en,
  // Pins
  input  wire fbl_pins_t pins_async,
  // Synchronised view
  output fbl_pins_t      pins_sync,
  output logic           sclk_rise,
  output logic           sclk_fall,
  output logic           cs_rise,
  output logic           cs_fall
);

  localparam fbl_pins_t PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1,
                                      rst_n: 1'b1, lines: 4'h0};

  fbl_pins_t meta_reg;
  fbl_pins_t sync_reg;
  fbl_pins_t prev_reg;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_reg <= PINS_IDLE;
      sync_reg <= PINS_IDLE;
      prev_reg <= PINS_IDLE;
    end
    else if (clk_en)
    begin
      meta_reg <= pins_async;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign pins_sync = sync_reg;
  assign sclk_rise = sync_reg.sclk & ~prev_reg.sclk;
  assign sclk_fall = ~sync_reg.sclk & prev_reg.sclk;
  assign cs_rise   = sync_reg.cs_n & ~prev_reg.cs_n;
  assign cs_fall   = ~sync_reg.cs_n & prev_reg.cs_n;

endmodule

// [fbl_flash_cmd.sv]
`timescale 1ns/1ps
// How it works
// R1: Lock bits apply only when protect-select set
// R2: Lock bits volatile, all set on reset
// R3: 36h plus address locks one region
// R4: 39h plus address unlocks one region
// R5: Host sends write-enable before lock commands
// R6: Unlock frame: opcode, three address bytes
// R7: Reject lock commands ending off byte boundary
// R8: 3Dh returns region lock status byte
// R9: Status 1 protected, 0 writable
// R10: Opcodes single-line 8 or quad 2 clocks
// R11: 7Eh locks every region
// R12: 98h unlocks every region
// R13: 66h then 99h resets volatile state
// R14: Other command cancels armed reset
// R15: Software reset aborts running program/erase
// R16: Reset pin low 1 us resets device
// R17: Data lines released while reset pin low
// R18: Host waits 1 us before select
// R19: Host waits recovery time after reset
// R20: 4Bh returns 128-bit unique identifier
// R21: 5Ah streams parameter table from address
// R22: Select rise ends parameter-table read anytime
// R23: Lock commands ignored without write-enable latch
module fbl_flash_cmd
  import fbl_pkg::*;
#(
  // Arbitrary identifier value
  parameter logic [127:0] UNIQUE_ID =
    128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978
)
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          resetn,
  input  wire logic          clk_en,
  // Serial pins
  input  wire logic          sclk,
  input  wire logic          cs_n,
  input  wire logic          reset_pin_n,
  input  wire logic [3:0]    serial_data_lines_in,
  output logic [3:0]         serial_data_lines_out,
  output logic [3:0]         serial_data_lines_oe,
  // Configuration
  input  wire logic          quad_opcode_mode,
  input  wire fbl_prot_cfg_t prot_cfg,
  input  wire logic          operation_in_progress_flag,
  input  wire logic [23:0]   query_addr,
  // Status
  output logic               write_enable_latch,
  output logic               query_protected,
  output logic               abort_operation,
  output logic               device_reset
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] region_index(input logic [23:0] a);
    logic [6:0] blk;
    logic [3:0] sct;
    blk = a[BLK_MSB:BLK_LSB];
    sct = a[SECT_MSB:SECT_LSB];
    if (blk == BOTTOM_BLOCK)
      region_index = SECT_BASE_LO | {4'h0, sct};
    else if (blk == TOP_BLOCK)
      region_index = SECT_BASE_HI | {4'h0, sct};
    else
      region_index = {1'b0, blk};
  endfunction

  function automatic logic [2:0] step(input logic quad);
    step = quad ? STEP_QUAD : STEP_SINGLE;
  endfunction

  function automatic logic field_protected(input logic [6:0] blk,
                                           input fbl_prot_cfg_t cfg);
    logic [7:0] span;
    logic       hit;
    span = 8'h00;
    if (cfg.block_protect_field == 5'h00)
      hit = 1'b0;
    else if (cfg.block_protect_field >= {1'b0, PROT_ALL})
      hit = 1'b1;
    else
    begin
      span = NUM_BLOCKS >> (PROT_ALL - cfg.block_protect_field[3:0]);
      hit  = {1'b0, blk} >= (NUM_BLOCKS - span);
    end
    field_protected = hit ^ cfg.protect_complement_bit;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  fbl_pins_t pins_s;
  logic      sclk_rise;
  logic      sclk_fall;
  logic      cs_rise;
  logic      cs_fall;

  fbl_pin_sync u_sync (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .clk_en     (clk_en),
    .pins_async ('{sclk: sclk, cs_n: cs_n, rst_n: reset_pin_n,
                   lines: serial_data_lines_in}),
    .pins_sync  (pins_s),
    .sclk_rise  (sclk_rise),
    .sclk_fall  (sclk_fall),
    .cs_rise    (cs_rise),
    .cs_fall    (cs_fall)
  );

  // ----------------------------------------------------------------
  // Reset pin filter
  // ----------------------------------------------------------------
  logic [7:0] rst_cnt_reg;
  logic       pin_reset_reg;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_cnt_reg   <= 8'h00;
      pin_reset_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (pins_s.rst_n)
      begin
        rst_cnt_reg   <= 8'h00;
        pin_reset_reg <= 1'b0;
      end
      else if (rst_cnt_reg == 8'(RESET_PULSE_CYC - 1))
        pin_reset_reg <= 1'b1;  // [R16]
      else
        rst_cnt_reg <= rst_cnt_reg + 8'h01;
    end
  end

  // Pulse once when the low time is reached
  logic pin_reset_go;
  assign pin_reset_go = ~pins_s.rst_n & ~pin_reset_reg
                        & (rst_cnt_reg == 8'(RESET_PULSE_CYC - 1));

  // ----------------------------------------------------------------
  // Frame decoder
  // ----------------------------------------------------------------
  fbl_state_t  state_reg;
  logic [7:0]  shift_reg;
  logic [2:0]  bit_cnt_reg;
  logic [1:0]  addr_cnt_reg;
  logic [23:0] addr_reg;
  logic [7:0]  opc_reg;
  logic        overrun_reg;
  logic        armed_reg;
  logic [7:0]  shift_next;
  logic [2:0]  bit_cnt_next;
  logic        active;
  logic        soft_reset;
  logic        any_reset;

  assign active     = ~pins_s.cs_n & pins_s.rst_n;
  assign any_reset  = soft_reset | pin_reset_go;
  assign shift_next = quad_opcode_mode  // [R10]
                      ? {shift_reg[3:0], pins_s.lines}
                      : {shift_reg[6:0], pins_s.lines[0]};
  assign bit_cnt_next = bit_cnt_reg + step(quad_opcode_mode);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg    <= ST_IDLE;
      shift_reg    <= 8'h00;
      bit_cnt_reg  <= 3'h0;
      addr_cnt_reg <= 2'h0;
      addr_reg     <= 24'h000000;
      opc_reg      <= 8'h00;
      overrun_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (any_reset || !active || cs_rise)
        state_reg <= ST_IDLE;  // [R22]
      else if (cs_fall || state_reg == ST_IDLE)
      begin
        state_reg    <= ST_OPC;
        bit_cnt_reg  <= 3'h0;
        addr_cnt_reg <= 2'h0;
        overrun_reg  <= 1'b0;
      end
      else if (sclk_rise && state_reg != ST_OUT)
      begin
        shift_reg   <= shift_next;
        bit_cnt_reg <= bit_cnt_next;
        if (bit_cnt_next == 3'h0)
        begin
          case (state_reg)
            ST_OPC:
            begin
              opc_reg <= shift_next;
              if (shift_next == SINGLE_REGION_LOCK_CMD
                  || shift_next == SINGLE_REGION_UNLOCK_CMD
                  || shift_next == READ_REGION_LOCK_CMD
                  || shift_next == READ_SERIAL_IDENTIFIER_CMD
                  || shift_next == READ_PARAMETER_TABLE_CMD)
                state_reg <= ST_ADDR;
              else
                state_reg <= ST_DONE;
            end
            ST_ADDR:
            begin
              addr_reg     <= {addr_reg[15:0], shift_next};
              addr_cnt_reg <= addr_cnt_reg + 2'h1;
              if (addr_cnt_reg == ADDR_LAST)
              begin
                if (opc_reg == READ_REGION_LOCK_CMD)
                  state_reg <= ST_OUT;  // [R8]
                else if (opc_reg == SINGLE_REGION_LOCK_CMD
                         || opc_reg == SINGLE_REGION_UNLOCK_CMD)
                  state_reg <= ST_DONE;
                else
                  state_reg <= ST_DUMMY;  // [R20] [R21]
              end
            end
            ST_DUMMY:
              state_reg <= ST_OUT;
            default:
              overrun_reg <= 1'b1;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Command execution at select release
  // ----------------------------------------------------------------
  logic frame_ok;
  logic do_we_set;
  logic do_lock;
  logic do_unlock;
  logic do_all_lock;
  logic do_all_unlock;
  logic we_gate;
  logic [7:0] exec_idx;

  assign frame_ok = cs_rise && state_reg == ST_DONE && !overrun_reg
                    && bit_cnt_reg == 3'h0;  // [R7]
  assign we_gate  = frame_ok && write_enable_latch;  // [R23]
  assign do_we_set = frame_ok && opc_reg == WRITE_ENABLE_CMD;
  assign do_lock  = we_gate && opc_reg == SINGLE_REGION_LOCK_CMD;
  assign do_unlock = we_gate && opc_reg == SINGLE_REGION_UNLOCK_CMD;
  assign do_all_lock = we_gate && opc_reg == ALL_REGIONS_LOCK_CMD;
  assign do_all_unlock = we_gate && opc_reg == ALL_REGIONS_UNLOCK_CMD;
  assign soft_reset = frame_ok && opc_reg == RESET_GO_CMD
                      && armed_reg;  // [R13]
  assign exec_idx = region_index(addr_reg);

  // Lock bits
  logic [NUM_REGIONS-1:0] lock_reg;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      lock_reg <= '1;  // [R2]
    else if (clk_en)
    begin
      if (any_reset)
        lock_reg <= '1;  // [R2] [R16]
      else if (do_all_lock)
        lock_reg <= '1;  // [R11]
      else if (do_all_unlock)
        lock_reg <= '0;  // [R12]
      else if (do_lock)
        lock_reg[exec_idx] <= 1'b1;  // [R3]
      else if (do_unlock)
        lock_reg[exec_idx] <= 1'b0;  // [R4]
    end
  end

  // Write-enable latch
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      write_enable_latch <= 1'b0;
    else if (clk_en)
    begin
      if (any_reset)
        write_enable_latch <= 1'b0;  // [R16]
      else if (do_we_set)
        write_enable_latch <= 1'b1;
      else if (do_lock || do_unlock || do_all_lock || do_all_unlock)
        write_enable_latch <= 1'b0;
    end
  end

  // Reset arming
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      armed_reg <= 1'b0;
    else if (clk_en)
    begin
      if (any_reset)
        armed_reg <= 1'b0;
      else if (frame_ok && opc_reg == RESET_ARM_CMD)
        armed_reg <= 1'b1;
      else if (cs_rise && opc_reg != RESET_ARM_CMD)
        armed_reg <= 1'b0;  // [R14]
    end
  end

  // Reset side effects
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      abort_operation <= 1'b0;
      device_reset    <= 1'b0;
    end
    else if (clk_en)
    begin
      abort_operation <= any_reset & operation_in_progress_flag;  // [R15]
      device_reset    <= any_reset;
    end
  end

  // ----------------------------------------------------------------
  // Protection view
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      query_protected <= 1'b1;
    else if (clk_en)
    begin
      if (prot_cfg.protect_select_bit)
        query_protected <= lock_reg[region_index(query_addr)];  // [R1]
      else
        query_protected <= field_protected(query_addr[BLK_MSB:BLK_LSB],
                                           prot_cfg);  // [R1]
    end
  end

  // ----------------------------------------------------------------
  // Read-out path
  // ----------------------------------------------------------------
  logic [7:0] out_reg;
  logic [2:0] out_cnt_reg;
  logic [7:0] out_idx_reg;
  logic [7:0] out_byte;
  logic [7:0] ptab_addr;

  assign ptab_addr = addr_reg[7:0] + out_idx_reg;

  always_comb
  begin
    out_byte = BLANK_BYTE;
    if (opc_reg == READ_REGION_LOCK_CMD)
      out_byte = {7'h00, lock_reg[exec_idx]};  // [R8] [R9]
    else if (opc_reg == READ_SERIAL_IDENTIFIER_CMD)
      out_byte = UNIQUE_ID[8 * (UID_BYTES - 1 - int'(out_idx_reg[3:0]))
                           +: 8];  // [R20]
    else if (ptab_addr < PTAB_LEN)
      out_byte = PTAB[ptab_addr[2:0]];  // [R21]
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_reg     <= 8'h00;
      out_cnt_reg <= 3'h0;
      out_idx_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      if (state_reg != ST_OUT)
      begin
        out_cnt_reg <= 3'h0;
        out_idx_reg <= 8'h00;
      end
      else if (sclk_fall)
      begin
        out_cnt_reg <= out_cnt_reg + step(quad_opcode_mode);
        if (out_cnt_reg == 3'h0)
        begin
          out_reg     <= out_byte;
          out_idx_reg <= out_idx_reg + 8'h01;
        end
        else if (quad_opcode_mode)
          out_reg <= {out_reg[3:0], 4'h0};
        else
          out_reg <= {out_reg[6:0], 1'b0};
      end
    end
  end

  assign serial_data_lines_out = quad_opcode_mode
                                 ? out_reg[7:4]
                                 : {2'b00, out_reg[7], 1'b0};
  assign serial_data_lines_oe  =
    (state_reg == ST_OUT && active && reset_pin_n)  // [R17]
    ? (quad_opcode_mode ? 4'hf : 4'h2) : 4'h0;

endmodule

// [fbl_flash_cmd_chk.sv]
`timescale 1ns/1ps
module fbl_flash_cmd_chk
  import fbl_pkg::*;
(
  // Clock and reset
  input wire logic          core_clk,
  input wire logic          resetn,
  // Pins and configuration
  input wire logic          cs_n,
  input wire logic          reset_pin_n,
  input wire logic          quad_opcode_mode,
  input wire fbl_prot_cfg_t prot_cfg,
  input wire logic [23:0]   query_addr,
  input wire logic [3:0]    serial_data_lines_oe,
  // Status
  input wire logic          write_enable_latch,
  input wire logic          query_protected,
  input wire logic          abort_operation,
  input wire logic          device_reset
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Protection expected from the block-protect field alone
  wire logic exp_field = prot_cfg.protect_complement_bit ^
                         (prot_cfg.block_protect_field != 5'h00);

  a_oe_pin_low: assert property (
    !reset_pin_n |-> serial_data_lines_oe == 4'h0)
    else $error("data lines driven while reset pin low");
  a_oe_lane_width: assert property (
    serial_data_lines_oe != 4'h0 |->
      serial_data_lines_oe == (quad_opcode_mode ? 4'hf : 4'h2))
    else $error("output enable does not match line mode");
  a_oe_select_end: assert property (
    cs_n [*6] |-> serial_data_lines_oe == 4'h0)
    else $error("data lines driven after select rose");
  a_bp_field_only: assert property (
    !prot_cfg.protect_select_bit && (prot_cfg.block_protect_field == 5'h00
      || prot_cfg.block_protect_field[4:3] != 2'h0)
    |=> query_protected == $past(exp_field))
    else $error("protection ignores block-protect field");
  a_unlock_needs_wel: assert property (
    $fell(query_protected) && prot_cfg.protect_select_bit &&
      $past(query_addr) == $past(query_addr, 2) &&
      $past(prot_cfg) == $past(prot_cfg, 2)
    |-> $past(write_enable_latch, 2) || $past(write_enable_latch, 3))
    else $error("lock cleared without write enable latch");
  a_wel_frame_end: assert property (
    $rose(write_enable_latch) |-> $past(cs_n, 2))
    else $error("write enable latch set inside a frame");
  a_reset_locks: assert property (
    device_reset && prot_cfg.protect_select_bit |-> ##[1:3] query_protected)
    else $error("locks not set by reset");
  a_reset_wel: assert property (
    device_reset |-> ##[0:2] !write_enable_latch)
    else $error("write enable latch kept over reset");
  a_abort_with_rst: assert property (
    abort_operation |-> device_reset)
    else $error("abort without reset");
  a_reset_pulse: assert property (
    device_reset |=> !device_reset)
    else $error("reset pulse longer than one cycle");
endmodule

bind fbl_flash_cmd fbl_flash_cmd_chk u_chk (.core_clk, .resetn, .cs_n,
  .reset_pin_n, .quad_opcode_mode, .prot_cfg, .query_addr,
  .serial_data_lines_oe, .write_enable_latch, .query_protected,
  .abort_operation, .device_reset);

// [fbl_host_model.sv]
`timescale 1ns/1ps
module fbl_host_model
  import fbl_pkg::*;
(
  // Clock
  input wire logic       core_clk,
  // Link
  input wire logic       quad_opcode_mode,
  input wire logic [3:0] lines,
  output logic           sclk,
  output logic           cs_n,
  output logic [3:0]     drv
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv  = 4'h0;
  end

  // One serial clock: data set while low, taken at the rise
  task tick(input logic [3:0] d, output logic [3:0] s);
    @(posedge core_clk) drv <= d;
    repeat (3) @(posedge core_clk);
    sclk <= 1'b1;
    repeat (3) @(posedge core_clk);
    s = lines;
    @(posedge core_clk) sclk <= 1'b0;
  endtask

  task send(input logic [7:0] b);
    logic [3:0] s;
    if (quad_opcode_mode)
    begin
      tick(b[7:4], s);
      tick(b[3:0], s);
    end
    else
      for (int i = 7; i >= 0; i--)
        tick({~drv[3:1], b[i]}, s);
  endtask

  // Released lines toggle so stale data never matches
  task recv(output logic [7:0] b);
    logic [3:0] s;
    for (int i = 0; i < (quad_opcode_mode ? 2 : 8); i++)
    begin
      tick(~drv, s);
      b = quad_opcode_mode ? {b[3:0], s} : {b[6:0], s[1]};
    end
  endtask

  task part(input int n);
    logic [3:0] s;
    for (int i = 0; i < n; i++)
      tick(~drv, s);
  endtask

  task open_f;
    @(posedge core_clk) cs_n <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  task close_f;
    repeat (2) @(posedge core_clk);
    cs_n <= 1'b1;
    repeat (10) @(posedge core_clk);
  endtask
endmodule

// [flash_block_lock_reset_id_cmds_tb_top.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, e, g)
module flash_block_lock_reset_id_cmds_tb_top
  import fbl_pkg::*;
;
  // Arbitrary identifier value
  localparam logic [127:0] UID = 128'h1122_3344_5566_7788_99aa_bbcc_ddee_f00f;
  logic          core_clk = 1'b0;
  logic          resetn;
  logic          reset_pin_n;
  logic          quad;
  logic          busy;
  fbl_prot_cfg_t cfg;
  logic [23:0]   query_addr;
  logic          sclk;
  logic          cs_n;
  logic [3:0]    drv;
  logic [3:0]    lines;
  logic [3:0]    lines_out;
  logic [3:0]    lines_oe;
  logic          we_latch;
  logic          qp;
  logic          abort_p;
  logic          rst_p;
  logic [7:0]    rx [16];
  int            n_errors = 0;
  int            n_compared = 0;
  int            n_rst = 0;
  int            n_abort = 0;
  int            cyc = 0;

  assign lines = (lines_oe & lines_out) | (~lines_oe & drv);
  always #5 core_clk = ~core_clk;

  fbl_flash_cmd #(.UNIQUE_ID(UID)) dut (.core_clk, .resetn, .clk_en(1'b1),
    .sclk, .cs_n, .reset_pin_n, .serial_data_lines_in(lines),
    .serial_data_lines_out(lines_out), .serial_data_lines_oe(lines_oe),
    .quad_opcode_mode(quad), .prot_cfg(cfg),
    .operation_in_progress_flag(busy), .query_addr,
    .write_enable_latch(we_latch), .query_protected(qp),
    .abort_operation(abort_p), .device_reset(rst_p));
  fbl_host_model host (.core_clk, .quad_opcode_mode(quad), .lines, .sclk,
    .cs_n, .drv);

  always @(posedge core_clk)
  begin
    cyc++;
    if (rst_p === 1'b1)
      n_rst++;
    if (abort_p === 1'b1)
      n_abort++;
    if (cyc == 40000)
    begin
      n_errors++;
      test_done;
    end
  end

  task check(input string nm, input logic [127:0] e, input logic [127:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Frame: opcode, address bytes, dummy, read bytes, stray bits
  task frame(input logic [7:0] c, input logic [23:0] a, input int na,
             input int nrx, input int extra);
    host.open_f;
    host.send(c);
    for (int i = 0; i < na; i++)
      host.send(a[23 - 8 * i -: 8]);
    if (c == READ_SERIAL_IDENTIFIER_CMD || c == READ_PARAMETER_TABLE_CMD)
      host.send(8'h00);
    for (int i = 0; i < nrx; i++)
      host.recv(rx[i]);
    host.part(extra);
    host.close_f;
  endtask

  task q(input logic [23:0] a);
    query_addr <= a;
    repeat (3) @(posedge core_clk);
  endtask

  task we_cmd;
    frame(WRITE_ENABLE_CMD, 24'h0, 0, 0, 0);
  endtask

  task t_region;
    `CHK("we_latch", 1'b0, we_latch);
    frame(READ_REGION_LOCK_CMD, 24'h050000, 3, 2, 0);
    `CHK("status", 8'h01, rx[0]);
    `CHK("status", 8'h01, rx[1]);
    we_cmd;
    `CHK("we_latch", 1'b1, we_latch);
    frame(SINGLE_REGION_UNLOCK_CMD, 24'h05abcd, 3, 0, 0);
    `CHK("we_latch", 1'b0, we_latch);
    q(24'h050000);
    `CHK("lock", 1'b0, qp);
    q(24'h060000);
    `CHK("lock", 1'b1, qp);
    frame(READ_REGION_LOCK_CMD, 24'h05ffff, 3, 1, 0);
    `CHK("status", 8'h00, rx[0]);
    frame(SINGLE_REGION_LOCK_CMD, 24'h050000, 3, 0, 0);
    q(24'h050000);
    `CHK("lock", 1'b0, qp);
    we_cmd;
    frame(SINGLE_REGION_LOCK_CMD, 24'h050000, 3, 0, 0);
    q(24'h050000);
    `CHK("lock", 1'b1, qp);
    we_cmd;
    frame(SINGLE_REGION_UNLOCK_CMD, 24'h070000, 3, 0, 3);
    frame(ALL_REGIONS_UNLOCK_CMD, 24'h0, 0, 0, 5);
    q(24'h070000);
    `CHK("lock", 1'b1, qp);
    $display("test region done");
  endtask

  task t_global;
    quad <= 1'b1;
    we_cmd;
    frame(ALL_REGIONS_UNLOCK_CMD, 24'h0, 0, 0, 0);
    q(24'h7f0000);
    `CHK("lock", 1'b0, qp);
    frame(READ_REGION_LOCK_CMD, 24'h000000, 3, 1, 0);
    `CHK("status", 8'h00, rx[0]);
    quad <= 1'b0;
    we_cmd;
    frame(ALL_REGIONS_LOCK_CMD, 24'h0, 0, 0, 0);
    q(24'h000000);
    `CHK("lock", 1'b1, qp);
    cfg <= {1'b0, 1'b0, 5'h00};
    q(24'h000000);
    `CHK("lock", 1'b0, qp);
    cfg <= {1'b0, 1'b1, 5'h00};
    q(24'h000000);
    `CHK("lock", 1'b1, qp);
    cfg <= {1'b0, 1'b1, 5'h08};
    q(24'h000000);
    `CHK("lock", 1'b0, qp);
    cfg <= {1'b0, 1'b0, 5'h01};
    q(24'h7f0000);
    `CHK("lock", 1'b1, qp);
    q(24'h7e0000);
    `CHK("lock", 1'b0, qp);
    cfg <= {1'b1, 1'b0, 5'h00};
    $display("test global done");
  endtask

  task t_reset;
    we_cmd;
    frame(ALL_REGIONS_UNLOCK_CMD, 24'h0, 0, 0, 0);
    frame(RESET_ARM_CMD, 24'h0, 0, 0, 0);
    we_cmd;
    frame(RESET_GO_CMD, 24'h0, 0, 0, 0);
    q(24'h010000);
    `CHK("lock", 1'b0, qp);
    `CHK("resets", 0, n_rst);
    busy <= 1'b1;
    frame(RESET_ARM_CMD, 24'h0, 0, 0, 0);
    frame(RESET_GO_CMD, 24'h0, 0, 0, 0);
    busy <= 1'b0;
    q(24'h010000);
    `CHK("lock", 1'b1, qp);
    `CHK("we_latch", 1'b0, we_latch);
    `CHK("resets", 1, n_rst);
    `CHK("aborts", 1, n_abort);
    we_cmd;
    frame(ALL_REGIONS_UNLOCK_CMD, 24'h0, 0, 0, 0);
    we_cmd;
    host.open_f;
    host.send(READ_REGION_LOCK_CMD);
    repeat (3) host.send(8'h02);
    host.recv(rx[0]);
    `CHK("status", 8'h00, rx[0]);
    `CHK("oe", 4'h2, lines_oe);
    busy <= 1'b1;
    reset_pin_n <= 1'b0;
    repeat (RESET_PULSE_CYC + 10) @(posedge core_clk);
    `CHK("oe", 4'h0, lines_oe);
    host.close_f;
    reset_pin_n <= 1'b1;
    busy <= 1'b0;
    repeat (3000) @(posedge core_clk);
    `CHK("resets", 2, n_rst);
    `CHK("aborts", 2, n_abort);
    `CHK("we_latch", 1'b0, we_latch);
    q(24'h020000);
    `CHK("lock", 1'b1, qp);
    $display("test reset done");
  endtask

  task t_reads;
    logic [7:0] exp_b;
    frame(READ_SERIAL_IDENTIFIER_CMD, 24'h000000, 3, 16, 0);
    for (int i = 0; i < UID_BYTES; i++)
      `CHK("uid", UID[127 - 8 * i -: 8], rx[i]);
    frame(READ_PARAMETER_TABLE_CMD, 24'h000005, 3, 4, 3);
    for (int i = 0; i < 4; i++)
    begin
      exp_b = (i + 5 < PTAB_LEN) ? PTAB[i + 5] : BLANK_BYTE;
      `CHK("table", exp_b, rx[i]);
    end
    frame(READ_REGION_LOCK_CMD, 24'h000000, 3, 1, 0);
    `CHK("status", 8'h01, rx[0]);
    $display("test reads done");
  endtask

  initial
  begin
    resetn = 1'b0;
    reset_pin_n = 1'b1;
    quad = 1'b0;
    busy = 1'b0;
    cfg = {1'b1, 1'b0, 5'h00};
    query_addr = 24'h0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge core_clk);
    t_region;
    t_global;
    t_reset;
    t_reads;
    test_done;
  end
endmodule
